// File: design/flash_status_lock_regs.sv
`timescale 1ns/100ps
`default_nettype none
// Function
// R1: key byte always reads 0x96
// R2: writes need key 0xA5, else reset
// R3: wrong key sets key-violation bit 1
// R4: key violation sticky; only software/brownout clear
// R5: seg lock: write 1 toggles, resets 1
// R6: seg lock 1 protects info segment
// R7: bit 5 emergency exit, resets 0
// R8: lock resets 1; write/erase only unlocked
// R9: setting lock does not abort a byte/word write or erase
// R10: lock during block write ends it
// R11: wait bit resets 1, shows readiness
// R12: bit 2 access-violation flag, read/write
// R13: bit 0 shows timing generator busy
// R14: bit 7 reserved reads zero
// R15: enable bit 5 gates access violation
// R16: software uses bit set/clear on enable
// R17: other enable bits left untouched
// R18: status at 0x012C, resets 0x9658
// R19: emergency exit clears control mode bits
// R20: interrupt when flag, enable and global
module flash_status_lock_regs (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic brownoutRst_n,
  input wire logic [15:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] ie1Others,
  input wire logic flashBusy,
  input wire logic flashWaitReady,
  input wire logic blockWriteMode,
  input wire logic accessViolationEvt,
  input wire logic globalIntEnable,
  output logic [15:0] rdata,
  output logic powerUpClearReset,
  output logic accessViolationIrq,
  output logic flashUnlocked,
  output logic infoSegProtect,
  output logic emergencyExit,
  output logic modeClear,
  output logic blockWriteEnd
);
  flash_lock_pkg::bus_req_s req;
  flash_lock_pkg::flash_stat_s stat;
  logic key_violation_flag_r, key_violation_flag_nxt;
  logic emergency_exit_r, emergency_exit_nxt;
  logic lock_r, lock_nxt;
  logic accv_r, accv_nxt;
  logic access_violation_int_enable_r, access_violation_int_enable_nxt;
  logic [15:0] rdata_r, rdata_nxt;
  logic irq_r, irq_nxt;
  logic unl_r, unl_nxt;
  logic prot_r, prot_nxt;
  logic mclr_r, mclr_nxt;
  logic bend_r, bend_nxt;
  logic busySync1_r, busySync_r;
  logic waitSync1_r, waitSync_r;
  logic segLock;
  logic hitStatus, hitCtrl, hitIe1;
  logic keyOk, keyBad, wrStatus;
  logic pucPulse;

  assign req = '{addr: addr, wdata: wdata, wr: wr, rd: rd};
  assign stat = '{busy: busySync_r, waitReady: waitSync_r,
                  blockWrite: blockWriteMode,
                  accessViolation: accessViolationEvt};

  assign hitStatus = (req.addr == flash_lock_pkg::ADDR_STATUS); // R18
  assign hitCtrl = hitStatus || (req.addr == flash_lock_pkg::ADDR_CTRL1)
                   || (req.addr == flash_lock_pkg::ADDR_CTRL2);
  assign hitIe1 = (req.addr == flash_lock_pkg::ADDR_IE1);
  assign keyOk = (req.wdata[flash_lock_pkg::KEY_HI:flash_lock_pkg::KEY_LO]
                  == flash_lock_pkg::KEY_WRITE); // R2
  assign keyBad = req.wr && hitCtrl && !keyOk; // R3
  assign wrStatus = req.wr && hitStatus && keyOk;

  // busy and wait come from the timing generator, treated as async
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busySync1_r <= 1'b0;
      busySync_r <= 1'b0;
      waitSync1_r <= 1'b1;
      waitSync_r <= 1'b1;
    end else begin
      busySync1_r <= flashBusy;
      busySync_r <= busySync1_r; // R13
      waitSync1_r <= flashWaitReady;
      waitSync_r <= waitSync1_r; // R11
    end
  end

  flash_toggle_bit #(
    .RESET_VAL(1'b1)
  ) u_seg_lock (
    .core_clk(core_clk),
    .nrst(nrst),
    .toggle(wrStatus && req.wdata[flash_lock_pkg::BIT_SEGLOCK]), // R5
    .q(segLock)
  );

  flash_puc_gen u_puc (
    .core_clk(core_clk),
    .nrst(nrst),
    .trigger(keyBad), // R2
    .pucPulse(pucPulse)
  );

  // key violation lives on the brownout reset only, so the reset it
  // causes does not wipe it
  always_comb begin
    key_violation_flag_nxt = key_violation_flag_r;
    if (wrStatus && !req.wdata[flash_lock_pkg::BIT_KEY_VIOLATION_FLAG]) begin
      key_violation_flag_nxt = 1'b0;
    end
    if (keyBad) begin
      key_violation_flag_nxt = 1'b1; // R3 R4
    end
  end

  always_ff @(posedge core_clk or negedge brownoutRst_n) begin
    if (!brownoutRst_n) begin
      key_violation_flag_r <= 1'b0;
    end else begin
      key_violation_flag_r <= key_violation_flag_nxt; // R4
    end
  end

  always_comb begin
    emergency_exit_nxt = emergency_exit_r;
    lock_nxt = lock_r;
    accv_nxt = accv_r;
    access_violation_int_enable_nxt = access_violation_int_enable_r;
    if (wrStatus) begin
      emergency_exit_nxt = req.wdata[flash_lock_pkg::BIT_EMERGENCY_EXIT]; // R7
      lock_nxt = req.wdata[flash_lock_pkg::BIT_LOCK]; // R8
      accv_nxt = req.wdata[flash_lock_pkg::BIT_ACCV]; // R12
    end
    if (stat.accessViolation) begin
      accv_nxt = 1'b1; // R12
    end
    if (req.wr && hitIe1) begin
      access_violation_int_enable_nxt = req.wdata[flash_lock_pkg::BIT_ACCESS_VIOLATION_INT_ENABLE]; // R15 R17
    end
    // a running byte/word write or erase is not aborted by lock
    unl_nxt = !lock_nxt; // R8 R9
    prot_nxt = segLock; // R6
    irq_nxt = accv_nxt && access_violation_int_enable_nxt && globalIntEnable; // R20
    mclr_nxt = emergency_exit_nxt; // R19
    bend_nxt = lock_nxt && !lock_r && stat.blockWrite
               && stat.waitReady; // R10
  end

  always_comb begin
    rdata_nxt = 16'h0000;
    if (req.rd && hitStatus) begin
      rdata_nxt[flash_lock_pkg::KEY_HI:flash_lock_pkg::KEY_LO] =
        flash_lock_pkg::KEY_READ; // R1
      rdata_nxt[flash_lock_pkg::BIT_RSVD] = 1'b0; // R14
      rdata_nxt[flash_lock_pkg::BIT_SEGLOCK] = segLock;
      rdata_nxt[flash_lock_pkg::BIT_EMERGENCY_EXIT] = emergency_exit_r;
      rdata_nxt[flash_lock_pkg::BIT_LOCK] = lock_r;
      rdata_nxt[flash_lock_pkg::BIT_WAIT] = stat.waitReady; // R11
      rdata_nxt[flash_lock_pkg::BIT_ACCV] = accv_r;
      rdata_nxt[flash_lock_pkg::BIT_KEY_VIOLATION_FLAG] = key_violation_flag_r;
      rdata_nxt[flash_lock_pkg::BIT_BUSY] = stat.busy; // R13
    end else if (req.rd && hitIe1) begin
      rdata_nxt[7:0] = ie1Others; // R17
      rdata_nxt[flash_lock_pkg::BIT_ACCESS_VIOLATION_INT_ENABLE] = access_violation_int_enable_r;
    end
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      emergency_exit_r <= flash_lock_pkg::STATUS_RESET[flash_lock_pkg::BIT_EMERGENCY_EXIT];
      lock_r <= flash_lock_pkg::STATUS_RESET[flash_lock_pkg::BIT_LOCK];
      accv_r <= flash_lock_pkg::STATUS_RESET[flash_lock_pkg::BIT_ACCV];
      access_violation_int_enable_r <= flash_lock_pkg::IE1_RESET[flash_lock_pkg::BIT_ACCESS_VIOLATION_INT_ENABLE];
      rdata_r <= 16'h0000;
      irq_r <= 1'b0;
      unl_r <= 1'b0;
      prot_r <= 1'b1;
      mclr_r <= 1'b0;
      bend_r <= 1'b0;
    end else begin
      emergency_exit_r <= emergency_exit_nxt;
      lock_r <= lock_nxt;
      accv_r <= accv_nxt;
      access_violation_int_enable_r <= access_violation_int_enable_nxt;
      rdata_r <= rdata_nxt;
      irq_r <= irq_nxt;
      unl_r <= unl_nxt;
      prot_r <= prot_nxt;
      mclr_r <= mclr_nxt;
      bend_r <= bend_nxt;
    end
  end

  assign rdata = rdata_r;
  assign powerUpClearReset = pucPulse;
  assign accessViolationIrq = irq_r;
  assign flashUnlocked = unl_r;
  assign infoSegProtect = prot_r;
  assign emergencyExit = emergency_exit_r;
  assign modeClear = mclr_r;
  assign blockWriteEnd = bend_r;

  property p_key_read;
    @(posedge core_clk) disable iff (!nrst)
      (rd && hitStatus) |=> (rdata[15:8] == 8'h96 && !rdata[7]);
  endproperty
  a_key_read: assert property (p_key_read) else $error("key byte bad"); // R1

  sequence s_puc_run;
    powerUpClearReset [*4];
  endsequence

  sequence s_bad_quiet;
    keyBad ##1 (!keyBad) [*4];
  endsequence

  property p_bad_key_puc;
    @(posedge core_clk) disable iff (!nrst)
      keyBad |=> s_puc_run;
  endproperty
  a_bad_key_puc: assert property (p_bad_key_puc) else $error("no reset"); // R2

  property p_puc_end;
    @(posedge core_clk) disable iff (!nrst)
      s_bad_quiet |=> !powerUpClearReset;
  endproperty
  a_puc_end: assert property (p_puc_end) else $error("reset too long"); // R2

  property p_key_violation_flag_set;
    @(posedge core_clk) disable iff (!brownoutRst_n)
      keyBad |=> key_violation_flag_r;
  endproperty
  a_key_violation_flag_set: assert property (p_key_violation_flag_set) else $error("key_violation_flag not set"); // R3

  property p_key_violation_flag_hold;
    @(posedge core_clk) disable iff (!brownoutRst_n)
      (key_violation_flag_r && !wrStatus) |=> key_violation_flag_r;
  endproperty
  a_key_violation_flag_hold: assert property (p_key_violation_flag_hold) else $error("key_violation_flag lost"); // R4

  property p_key_violation_flag_clear;
    @(posedge core_clk) disable iff (!brownoutRst_n)
      (wrStatus && !wdata[flash_lock_pkg::BIT_KEY_VIOLATION_FLAG]) |=> !key_violation_flag_r;
  endproperty
  a_key_violation_flag_clear: assert property (p_key_violation_flag_clear) else $error("key_violation_flag kept"); // R4

  property p_seg_toggle;
    @(posedge core_clk) disable iff (!nrst)
      (wrStatus && wdata[6]) |=> (segLock != $past(segLock));
  endproperty
  a_seg_toggle: assert property (p_seg_toggle) else $error("no toggle"); // R5

  property p_seg_hold;
    @(posedge core_clk) disable iff (!nrst)
      !(wrStatus && wdata[flash_lock_pkg::BIT_SEGLOCK]) |=> $stable(segLock);
  endproperty
  a_seg_hold: assert property (p_seg_hold) else $error("seg moved"); // R5

  property p_unlock;
    @(posedge core_clk) disable iff (!nrst)
      (wrStatus && !wdata[4]) |=> flashUnlocked;
  endproperty
  a_unlock: assert property (p_unlock) else $error("not unlocked"); // R8

  property p_irq;
    @(posedge core_clk) disable iff (!nrst)
      (accv_r && access_violation_int_enable_r && $past(globalIntEnable)) |-> accessViolationIrq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq missing"); // R20

  property p_irq_off;
    @(posedge core_clk) disable iff (!nrst)
      !(accv_r && access_violation_int_enable_r) |-> !accessViolationIrq;
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("stray irq"); // R20

  property p_accv_set;
    @(posedge core_clk) disable iff (!nrst)
      accessViolationEvt |=> accv_r;
  endproperty
  a_accv_set: assert property (p_accv_set) else $error("accv lost"); // R12

  property p_emergency_exit_clear;
    @(posedge core_clk) disable iff (!nrst)
      (wrStatus && wdata[flash_lock_pkg::BIT_EMERGENCY_EXIT]) |=> modeClear;
  endproperty
  a_emergency_exit_clear: assert property (p_emergency_exit_clear) else $error("no clear"); // R19

  property p_block_end;
    @(posedge core_clk) disable iff (!nrst)
      (wrStatus && wdata[flash_lock_pkg::BIT_LOCK] && !lock_r
       && blockWriteMode && waitSync_r) |=> blockWriteEnd;
  endproperty
  a_block_end: assert property (p_block_end) else $error("no end"); // R10

  property p_ie_read;
    @(posedge core_clk) disable iff (!nrst)
      (rd && hitIe1) |=> (rdata[7:6] == $past(ie1Others[7:6])
                          && rdata[4:0] == $past(ie1Others[4:0]));
  endproperty
  a_ie_read: assert property (p_ie_read) else $error("ie bits"); // R17

  property p_busy_sync;
    @(posedge core_clk) disable iff (!nrst)
      busySync_r == $past(flashBusy, 2);
  endproperty
  a_busy_sync: assert property (p_busy_sync) else $error("busy lag"); // R13

  property p_wait_sync;
    @(posedge core_clk) disable iff (!nrst)
      waitSync_r == $past(flashWaitReady, 2);
  endproperty
  a_wait_sync: assert property (p_wait_sync) else $error("wait lag"); // R11
endmodule
`default_nettype wire

// File: design/flash_lock_pkg.sv
`default_nettype none
package flash_lock_pkg;

  localparam logic [15:0] ADDR_IE1 = 16'h0000;
  localparam logic [15:0] ADDR_STATUS = 16'h012C;
  localparam logic [15:0] ADDR_CTRL1 = 16'h0128;
  localparam logic [15:0] ADDR_CTRL2 = 16'h012A;

  localparam logic [7:0] KEY_READ = 8'h96;
  localparam logic [7:0] KEY_WRITE = 8'hA5;
  localparam logic [15:0] STATUS_RESET = 16'h9658;
  localparam logic [7:0] IE1_RESET = 8'h00;

  localparam int KEY_HI = 15;
  localparam int KEY_LO = 8;
  localparam int BIT_RSVD = 7;
  localparam int BIT_SEGLOCK = 6;
  localparam int BIT_EMERGENCY_EXIT = 5;
  localparam int BIT_LOCK = 4;
  localparam int BIT_WAIT = 3;
  localparam int BIT_ACCV = 2;
  localparam int BIT_KEY_VIOLATION_FLAG = 1;
  localparam int BIT_BUSY = 0;
  localparam int BIT_ACCESS_VIOLATION_INT_ENABLE = 5;

  // control-register mode bits cleared by emergency exit
  localparam int BIT_BLOCK_WRITE_MODE = 7;
  localparam int BIT_WRT = 6;
  localparam int BIT_MASS_ERASE_SELECT = 2;
  localparam int BIT_ERASE = 1;

  // length of the power-up-clear pulse, in core clock cycles
  localparam int PUC_CYCLES = 4;
  localparam logic [2:0] PUC_CNT_INIT = 3'h4;

  typedef struct packed {
    logic [15:0] addr;
    logic [15:0] wdata;
    logic wr;
    logic rd;
  } bus_req_s;

  typedef struct packed {
    logic busy;
    logic waitReady;
    logic blockWrite;
    logic accessViolation;
  } flash_stat_s;

  typedef struct packed {
    logic blockWriteEnd;
    logic modeClear;
    logic flashUnlocked;
    logic infoSegProtect;
  } flash_ctl_s;

endpackage
`default_nettype wire

// File: design/flash_toggle_bit.sv
`timescale 1ns/100ps
`default_nettype none
module flash_toggle_bit #(
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic toggle,
  output var logic q
);
  logic state_r;
  logic state_nxt;

  always_comb begin
    state_nxt = state_r ^ toggle;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state_r <= RESET_VAL;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign q = state_r;
endmodule
`default_nettype wire

// File: design/flash_puc_gen.sv
`timescale 1ns/100ps
`default_nettype none
module flash_puc_gen (
  input wire logic core_clk,
  input wire logic nrst,
  input wire logic trigger,
  output logic pucPulse
);
  logic [2:0] cnt_r;
  logic [2:0] cnt_nxt;
  logic puc_r;
  logic puc_nxt;

  // a bad key starts a fixed-length reset pulse
  always_comb begin
    cnt_nxt = cnt_r;
    if (trigger) begin
      cnt_nxt = flash_lock_pkg::PUC_CNT_INIT;
    end else if (cnt_r != 3'h0) begin
      cnt_nxt = cnt_r - 3'h1;
    end
    puc_nxt = (cnt_nxt != 3'h0);
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      cnt_r <= 3'h0;
      puc_r <= 1'b0;
    end else begin
      cnt_r <= cnt_nxt;
      puc_r <= puc_nxt;
    end
  end

  assign pucPulse = puc_r;
endmodule
`default_nettype wire

// File: tb/flash_status_lock_regs_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module flash_status_lock_regs_tb_top;
  localparam logic [15:0] SA = flash_lock_pkg::ADDR_STATUS;
  localparam logic [15:0] IEA = flash_lock_pkg::ADDR_IE1;
  logic core_clk, nrst, brownoutRst_n, wr, rd, flashBusy, flashWaitReady;
  logic blockWriteMode, accessViolationEvt, globalIntEnable;
  logic [15:0] addr, wdata, rdata;
  logic [7:0] ie1Others;
  logic powerUpClearReset, accessViolationIrq, flashUnlocked;
  logic infoSegProtect, emergencyExit, modeClear, blockWriteEnd;
  int error_cnt, comparisons, pucCnt, bweCnt, cycles;
  int pucBase, bweBase;

  flash_status_lock_regs DUT (.core_clk, .nrst, .brownoutRst_n, .addr,
    .wdata, .wr, .rd, .ie1Others, .flashBusy, .flashWaitReady,
    .blockWriteMode, .accessViolationEvt, .globalIntEnable, .rdata,
    .powerUpClearReset, .accessViolationIrq, .flashUnlocked,
    .infoSegProtect, .emergencyExit, .modeClear, .blockWriteEnd);

  initial begin
    core_clk = 1'b0;
    forever #2 core_clk = ~core_clk;
  end

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // pulse counters and hang guard
  always @(posedge core_clk) begin
    cycles++;
    if (powerUpClearReset === 1'b1) pucCnt++;
    if (blockWriteEnd === 1'b1) bweCnt++;
    if (cycles == 5000) begin
      error_cnt++;
      $display("BAD t=%0t run did not finish", $time);
      tally_and_finish();
    end
  end

  task automatic chk(input logic [15:0] got, exp, input string msg);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task automatic wreg(input logic [15:0] a, d);
    @(posedge core_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge core_clk);
    wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rchk(input logic [15:0] a, m, e, input string msg);
    @(posedge core_clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge core_clk);
    rd <= 1'b0;
    @(negedge core_clk);
    chk(rdata & m, e, msg);
  endtask

  task automatic look(input int n);
    repeat (n) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  initial begin
    nrst = 1'b0;
    brownoutRst_n = 1'b0;
    {wr, rd, flashBusy, blockWriteMode} = '0;
    {accessViolationEvt, globalIntEnable} = '0;
    flashWaitReady = 1'b1;
    addr = '0;
    wdata = '0;
    ie1Others = 8'hDB;
    repeat (10) @(posedge core_clk);
    nrst <= 1'b1;
    brownoutRst_n <= 1'b1;
    look(1);
    chk({15'h0, infoSegProtect}, 16'h0001, "seg protect rst");
    chk({15'h0, flashUnlocked}, 16'h0000, "unlocked rst");
    rchk(SA, 16'hFFFF, 16'h9658, "status rst");
    rchk(IEA, 16'h00FF, 16'h00DB, "ie rst");
    rchk(16'h0200, 16'hFFFF, 16'h0000, "unmapped");
    $display("test reset done");
    wreg(SA, 16'hA589);
    look(2);
    chk({15'h0, flashUnlocked}, 16'h0001, "unlock");
    rchk(SA, 16'hFFFF, 16'h9648, "ro bits");
    wreg(SA, 16'hA540);
    look(2);
    chk({15'h0, infoSegProtect}, 16'h0000, "seg toggle");
    wreg(SA, 16'hA500);
    rchk(SA, 16'h0040, 16'h0000, "seg write 0");
    wreg(SA, 16'hA540);
    look(2);
    chk({15'h0, infoSegProtect}, 16'h0001, "seg back");
    $display("test lock done");
    wreg(SA, 16'hA520);
    look(2);
    chk({15'h0, emergencyExit}, 16'h0001, "emergency_exit");
    chk({15'h0, modeClear}, 16'h0001, "mode clear");
    rchk(SA, 16'h0020, 16'h0020, "emergency_exit rd");
    wreg(SA, 16'hA500);
    look(2);
    chk({15'h0, emergencyExit}, 16'h0000, "emergency_exit off");
    $display("test exit done");
    @(posedge core_clk);
    globalIntEnable <= 1'b1;
    accessViolationEvt <= 1'b1;
    @(posedge core_clk);
    accessViolationEvt <= 1'b0;
    rchk(SA, 16'h0004, 16'h0004, "accv set");
    wreg(IEA, 16'h00FB);
    look(2);
    chk({15'h0, accessViolationIrq}, 16'h0001, "irq");
    rchk(IEA, 16'h00FF, 16'h00FB, "ie set");
    @(posedge core_clk);
    globalIntEnable <= 1'b0;
    look(2);
    chk({15'h0, accessViolationIrq}, 16'h0000, "irq gie");
    @(posedge core_clk);
    globalIntEnable <= 1'b1;
    wreg(SA, 16'hA500);
    look(2);
    chk({15'h0, accessViolationIrq}, 16'h0000, "irq clr");
    rchk(SA, 16'h0004, 16'h0000, "accv clr");
    $display("test access done");
    @(posedge core_clk);
    flashBusy <= 1'b1;
    flashWaitReady <= 1'b0;
    look(4);
    rchk(SA, 16'h0009, 16'h0001, "busy");
    @(posedge core_clk);
    flashBusy <= 1'b0;
    flashWaitReady <= 1'b1;
    blockWriteMode <= 1'b1;
    look(4);
    rchk(SA, 16'h0009, 16'h0008, "idle");
    bweBase = bweCnt;
    wreg(SA, 16'hA510);
    look(4);
    chk(16'(bweCnt - bweBase), 16'h0001, "block end");
    chk({15'h0, flashUnlocked}, 16'h0000, "relock");
    @(posedge core_clk);
    blockWriteMode <= 1'b0;
    $display("test status done");
    pucBase = pucCnt;
    wreg(SA, 16'h0000);
    look(8);
    chk(16'(pucCnt - pucBase), 16'h0004, "puc len");
    rchk(SA, 16'hFF02, 16'h9602, "key_violation_flag");
    wreg(SA, 16'hA502);
    rchk(SA, 16'h0002, 16'h0002, "key_violation_flag kept");
    @(posedge core_clk);
    brownoutRst_n <= 1'b0;
    @(posedge core_clk);
    brownoutRst_n <= 1'b1;
    rchk(SA, 16'h0002, 16'h0000, "key_violation_flag bor");
    pucBase = pucCnt;
    wreg(flash_lock_pkg::ADDR_CTRL1, 16'h9600);
    look(8);
    chk(16'(pucCnt - pucBase), 16'h0004, "puc ctrl1");
    rchk(SA, 16'h0002, 16'h0002, "key_violation_flag ctrl1");
    wreg(SA, 16'hA500);
    rchk(SA, 16'h0002, 16'h0000, "key_violation_flag sw clr");
    $display("test key done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
